// >>> core/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
    localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TRIM_HIGH = 8'h04;
    localparam logic [7:0] ADDR_INTEGRITY = 8'h08;
    localparam logic [7:0] ADDR_PLL_TEST = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CALIB = 8'h14;
    localparam logic [7:0] ADDR_CALIB_LO = 8'h18;

    localparam logic [7:0] CLK_CTRL_RST = 8'h00;
    localparam logic [7:0] TRIM_HIGH_RST = 8'hff;
    localparam logic [7:0] TRIM_SEARCH_START = 8'h80;
    localparam int CLK_OUT_BIT = 1;
    localparam int SLOW_BIT = 0;
    localparam int TRIM_LO_POS = 5;
    localparam int LOCK_BIT = 0;
    localparam int HALF_DIV_BIT = 0;

    localparam logic [15:0] CAL5_HI_ADDR = 16'hdee0;
    localparam logic [15:0] CAL5_LO_ADDR = 16'hdee1;
    localparam logic [15:0] CAL3_HI_ADDR = 16'hdee2;
    localparam logic [15:0] CAL3_LO_ADDR = 16'hdee3;

    localparam int SLOW_DIV = 32;
    localparam int PLL_MUL_LOW = 4;
    localparam int PLL_MUL_HIGH = 8;
    localparam int TIMER_MUL = 4;

    localparam int STARTUP_US = 1000;
    localparam int CLK_MHZ = 200;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SRC_EXT = 2'b00,
        SRC_XTAL = 2'b01,
        SRC_RC = 2'b10
    } src_e;

    typedef enum logic [1:0] {
        PLL_OFF = 2'b00,
        PLL_WAIT = 2'b01,
        PLL_PLL_LOCK_FLAG = 2'b10
    } pll_e;
endpackage

// >>> core/slow_divider.sv
`timescale 1ns/100ps
// glitch-free: selection switches only at the end of a divided period,
// so the core enable never yields a short or doubled period
module slow_divider (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic osc_en_i,
    input wire logic slow_i,
    output logic core_en_o,
    output logic slow_active_o
);
    logic [4:0] cnt_r;
    logic slow_r;
    logic wrap;

    assign wrap = (cnt_r == 5'(clk_ctrl_pkg::SLOW_DIV - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 5'h0;
        end else if (osc_en_i) begin
            cnt_r <= wrap ? 5'h0 : cnt_r + 5'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_r <= 1'b0;
        end else if (osc_en_i && wrap) begin
            slow_r <= slow_i;
        end
    end

    assign core_en_o = osc_en_i && (!slow_r || wrap);
    assign slow_active_o = slow_r;

    chk_slow_period: assert property (@(posedge clk_i) disable iff (rst_i)
        (core_en_o && slow_r && $past(slow_r)) |-> (cnt_r == 5'h1f))
        else $error("slow core pulse off period boundary");
endmodule // slow_divider

// >>> core/clk_ctrl.sv
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
// Operation
// - trim register resets to all ones
// - ten-bit trim, low two in integrity bits
// - trim zero fastest, all ones slowest
// - calibration bytes at fixed nonvolatile addresses
// - low calibration bits sit at 6:5
// - calibration bytes are read-only
// - programming entry forces internal RC source
// - PLL multiplies 1MHz by 4 or 8
// - no PLL: RC or external clock
// - PLL output held until startup delay
// - lock flag set when PLL ready
// - half divider gives 4MHz from x8
// - bit 1 enables clock output
// - bit 0 selects divide by 32
// - control resets zero, reserved bits zero
// - timer quadrupler needs 8MHz input
// - source chosen by option byte
module clk_ctrl #(
    parameter int STARTUP_CYCLES = clk_ctrl_pkg::STARTUP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] opt_src_i,
    input wire logic opt_pll_en_i,
    input wire logic opt_pll_x8_i,
    input wire logic opt_xtal_half_i,
    input wire logic opt_timer_mul_en_i,
    input wire logic prog_entry_i,
    input wire logic wake_i,
    input wire logic osc_tick_i,
    input wire logic [7:0] cal5_hi_i,
    input wire logic [7:0] cal5_lo_i,
    input wire logic [7:0] cal3_hi_i,
    input wire logic [7:0] cal3_lo_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [9:0] rc_trim_code_o,
    output logic [1:0] src_sel_o,
    output logic pll_run_o,
    output logic [3:0] pll_mul_o,
    output logic pll_half_o,
    output logic osc_gate_o,
    output logic core_en_o,
    output logic clk_out_en_o,
    output logic timer_mul_en_o
);
    logic [7:0] clk_ctrl_r;
    logic [7:0] trim_high_r;
    logic [1:0] trim_low_r;
    logic half_div_r;
    logic lock_r;
    logic [31:0] start_cnt_r;
    clk_ctrl_pkg::pll_e pll_state_r;
    logic [1:0] src_r;
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_nxt;
    logic rd_ok;
    logic core_en;
    logic slow_active;

    // source selection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_r <= clk_ctrl_pkg::SRC_RC;
        end else if (prog_entry_i) begin
            src_r <= clk_ctrl_pkg::SRC_RC;
        end else begin
            src_r <= opt_src_i;
        end
    end
    assign src_sel_o = src_r;

    // PLL startup and lock
    always_ff @(posedge clk_i) begin
        if (rst_i || wake_i || !opt_pll_en_i) begin
            pll_state_r <= opt_pll_en_i ? clk_ctrl_pkg::PLL_WAIT : clk_ctrl_pkg::PLL_OFF;
            start_cnt_r <= 32'h0000_0000;
        end else begin
            case (pll_state_r)
                clk_ctrl_pkg::PLL_WAIT: begin
                    if (start_cnt_r == 32'(STARTUP_CYCLES - 1)) begin
                        pll_state_r <= clk_ctrl_pkg::PLL_PLL_LOCK_FLAG;
                    end else begin
                        start_cnt_r <= start_cnt_r + 32'h0000_0001;
                    end
                end
                clk_ctrl_pkg::PLL_PLL_LOCK_FLAG: pll_state_r <= clk_ctrl_pkg::PLL_PLL_LOCK_FLAG;
                clk_ctrl_pkg::PLL_OFF: pll_state_r <= clk_ctrl_pkg::PLL_WAIT;
                default: pll_state_r <= clk_ctrl_pkg::PLL_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_r <= 1'b0;
        end else begin
            lock_r <= (pll_state_r == clk_ctrl_pkg::PLL_PLL_LOCK_FLAG);
        end
    end

    assign pll_run_o = opt_pll_en_i && (src_r != clk_ctrl_pkg::SRC_XTAL);
    assign pll_mul_o = opt_pll_x8_i ? 4'(clk_ctrl_pkg::PLL_MUL_HIGH)
                                    : 4'(clk_ctrl_pkg::PLL_MUL_LOW);
    assign pll_half_o = half_div_r && opt_pll_x8_i;
    assign osc_gate_o = !opt_pll_en_i || lock_r;
    assign timer_mul_en_o = opt_timer_mul_en_i
        && ((opt_pll_en_i && opt_pll_x8_i && lock_r && !half_div_r)
            || (!opt_pll_en_i && opt_xtal_half_i));

    slow_divider u_slow (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_en_i(osc_tick_i && osc_gate_o),
        .slow_i(clk_ctrl_r[clk_ctrl_pkg::SLOW_BIT]),
        .core_en_o(core_en),
        .slow_active_o(slow_active)
    );
    assign core_en_o = core_en;
    assign clk_out_en_o = clk_ctrl_r[clk_ctrl_pkg::CLK_OUT_BIT];
    assign rc_trim_code_o = {trim_high_r, trim_low_r};

    // AXI write channel
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign wr_hit = (awaddr_r == clk_ctrl_pkg::ADDR_CLK_CTRL)
        || (awaddr_r == clk_ctrl_pkg::ADDR_TRIM_HIGH)
        || (awaddr_r == clk_ctrl_pkg::ADDR_INTEGRITY)
        || (awaddr_r == clk_ctrl_pkg::ADDR_PLL_TEST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bvalid_r <= 1'b0;
            bresp_r <= clk_ctrl_pkg::AXI_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? clk_ctrl_pkg::AXI_OKAY : clk_ctrl_pkg::AXI_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // register writes; calibration bytes are never writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_ctrl_r <= clk_ctrl_pkg::CLK_CTRL_RST;
            trim_high_r <= clk_ctrl_pkg::TRIM_HIGH_RST;
            trim_low_r <= 2'b11;
            half_div_r <= 1'b0;
        end else if (do_write && wstrb_r[0]) begin
            case (awaddr_r)
                clk_ctrl_pkg::ADDR_CLK_CTRL:
                    clk_ctrl_r <= {6'b00_0000, wdata_r[1:0]};
                clk_ctrl_pkg::ADDR_TRIM_HIGH: trim_high_r <= wdata_r[7:0];
                clk_ctrl_pkg::ADDR_INTEGRITY:
                    trim_low_r <= wdata_r[clk_ctrl_pkg::TRIM_LO_POS +: 2];
                clk_ctrl_pkg::ADDR_PLL_TEST:
                    half_div_r <= wdata_r[clk_ctrl_pkg::HALF_DIV_BIT];
                default: clk_ctrl_r <= clk_ctrl_r;
            endcase
        end
    end

    // read mux
    always_comb begin
        rd_nxt = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            clk_ctrl_pkg::ADDR_CLK_CTRL: rd_nxt = {24'h00_0000, clk_ctrl_r};
            clk_ctrl_pkg::ADDR_TRIM_HIGH: rd_nxt = {24'h00_0000, trim_high_r};
            clk_ctrl_pkg::ADDR_INTEGRITY: begin
                rd_nxt[clk_ctrl_pkg::TRIM_LO_POS +: 2] = trim_low_r;
                rd_nxt[clk_ctrl_pkg::LOCK_BIT] = lock_r;
            end
            clk_ctrl_pkg::ADDR_PLL_TEST: rd_nxt[clk_ctrl_pkg::HALF_DIV_BIT] = half_div_r;
            clk_ctrl_pkg::ADDR_STATUS: rd_nxt = {26'h0, slow_active, pll_state_r,
                                                  src_r, lock_r};
            // 5 V pair in low half, 3.3 V pair in high half
            clk_ctrl_pkg::ADDR_CALIB: rd_nxt = {cal3_lo_i, cal3_hi_i, cal5_lo_i, cal5_hi_i};
            clk_ctrl_pkg::ADDR_CALIB_LO: rd_nxt = {30'h0, cal5_lo_i[clk_ctrl_pkg::TRIM_LO_POS +: 2]};
            default: rd_ok = 1'b0;
        endcase
    end

    assign s_axi_arready = !rvalid_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= clk_ctrl_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_nxt;
            rresp_r <= rd_ok ? clk_ctrl_pkg::AXI_OKAY : clk_ctrl_pkg::AXI_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    chk_trim_reset: assert property (@(posedge clk_i)
        $past(rst_i) |-> trim_high_r == clk_ctrl_pkg::TRIM_HIGH_RST)
        else $error("trim not all ones after reset");
    chk_trim_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        (do_write && wstrb_r[0] && awaddr_r == clk_ctrl_pkg::ADDR_TRIM_HIGH)
        |=> rc_trim_code_o[9:2] == $past(wdata_r[7:0]))
        else $error("trim code not updated");
    chk_prog_rc: assert property (@(posedge clk_i) disable iff (rst_i)
        prog_entry_i |=> src_sel_o == clk_ctrl_pkg::SRC_RC)
        else $error("programming entry did not force rc");
    chk_no_early: assert property (@(posedge clk_i) disable iff (rst_i)
        (opt_pll_en_i && pll_state_r != clk_ctrl_pkg::PLL_PLL_LOCK_FLAG) |=> !osc_gate_o)
        else $error("pll clock passed before startup");
    chk_lock_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (pll_state_r == clk_ctrl_pkg::PLL_PLL_LOCK_FLAG) |=> lock_r)
        else $error("lock flag not set");
    chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_ctrl_r[7:2] == 6'h00)
        else $error("reserved control bits set");
    chk_out_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        clk_out_en_o == clk_ctrl_r[clk_ctrl_pkg::CLK_OUT_BIT])
        else $error("clock output enable mismatch");
    chk_wr_resp: assert property (@(posedge clk_i) disable iff (rst_i)
        do_write |=> s_axi_bvalid)
        else $error("no write response");
endmodule // clk_ctrl

// >>> tb/clk_ctrl_tb.sv
`timescale 1ns/100ps
module clk_ctrl_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] opt_src_i = 2'b10;
    logic opt_pll_en_i = 1'b0;
    logic opt_pll_x8_i = 1'b1;
    logic opt_xtal_half_i = 1'b0;
    logic opt_timer_mul_en_i = 1'b0;
    logic prog_entry_i = 1'b0;
    logic wake_i = 1'b0;
    logic osc_tick_i = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, src_sel_o;
    logic [31:0] s_axi_rdata;
    logic [9:0] rc_trim_code_o;
    logic [3:0] pll_mul_o;
    logic pll_run_o, pll_half_o, osc_gate_o, core_en_o, clk_out_en_o, timer_mul_en_o;
    int err_total = 0;
    int cmp_count = 0;
    logic [1:0] rsp;
    logic [31:0] rd;
    int g;

    always #2.5 clk_i = ~clk_i;

    // startup shortened so the lock wait stays about twenty cycles
    clk_ctrl #(.STARTUP_CYCLES(20)) u_dut (.*, .cal5_hi_i(8'h5a), .cal5_lo_i(8'h40),
        .cal3_hi_i(8'ha5), .cal3_lo_i(8'h20));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic hang();
        err_total++;
        $display("BAD t=%0t wait ran out", $time);
        test_done();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        resp = 2'b11;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                break;
            end
        end
        if (n == 64)
            hang();
        s_axi_bready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_x(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                break;
            end
        end
        if (n == 64)
            hang();
        s_axi_rready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd_x(a, d, r);
        chk(d & m, e);
    endtask

    task automatic gap(output int n);
        for (n = 1; n < 100; n++) begin
            @(posedge clk_i);
            if (core_en_o)
                break;
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        hang();
    end

    initial begin
        do_reset();
        rd_chk(clk_ctrl_pkg::ADDR_CLK_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(clk_ctrl_pkg::ADDR_TRIM_HIGH, 32'hffff_ffff, 32'h0000_00ff);
        chk(rc_trim_code_o, 32'h0000_03ff);
        wr(clk_ctrl_pkg::ADDR_TRIM_HIGH, 32'h0000_0080, rsp);
        chk(rc_trim_code_o, 32'h0000_0203);
        wr(clk_ctrl_pkg::ADDR_INTEGRITY, 32'h0000_0040, rsp);
        chk(rc_trim_code_o, 32'h0000_0202);
        rd_chk(clk_ctrl_pkg::ADDR_INTEGRITY, 32'h0000_0060, 32'h0000_0040);
        wr(clk_ctrl_pkg::ADDR_TRIM_HIGH, 32'h0000_0000, rsp);
        chk(rc_trim_code_o, 32'h0000_0002);
        wr(clk_ctrl_pkg::ADDR_CLK_CTRL, 32'h0000_00fe, rsp);
        rd_chk(clk_ctrl_pkg::ADDR_CLK_CTRL, 32'hffff_ffff, 32'h0000_0002);
        chk(clk_out_en_o, 32'h0000_0001);
        wr(clk_ctrl_pkg::ADDR_CLK_CTRL, 32'h0000_0000, rsp);
        chk(clk_out_en_o, 32'h0000_0000);
        wr(8'h1c, 32'h0000_00ff, rsp);
        chk(rsp, clk_ctrl_pkg::AXI_SLVERR);
        rd_x(8'h1c, rd, rsp);
        chk(rsp, clk_ctrl_pkg::AXI_SLVERR);
        rd_chk(clk_ctrl_pkg::ADDR_CALIB, 32'hffff_ffff, 32'h20a5_405a);
        rd_chk(clk_ctrl_pkg::ADDR_CALIB_LO, 32'hffff_ffff, 32'h0000_0002);
        wr(clk_ctrl_pkg::ADDR_CALIB, 32'h0000_0000, rsp);
        chk(rsp, clk_ctrl_pkg::AXI_SLVERR);
        rd_chk(clk_ctrl_pkg::ADDR_CALIB, 32'hffff_ffff, 32'h20a5_405a);
        opt_pll_en_i <= 1'b1;
        opt_pll_x8_i <= 1'b0;
        settle();
        chk(pll_mul_o, 32'h0000_0004);
        chk(pll_run_o, 32'h0000_0001);
        opt_pll_x8_i <= 1'b1;
        settle();
        chk(pll_mul_o, 32'h0000_0008);
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        for (g = 0; g < 100 && !osc_gate_o; g++)
            @(posedge clk_i);
        chk(g >= 18 && g <= 26, 32'h0000_0001);
        rd_chk(clk_ctrl_pkg::ADDR_INTEGRITY, 32'h0000_0001, 32'h0000_0001);
        opt_timer_mul_en_i <= 1'b1;
        settle();
        chk(timer_mul_en_o, 32'h0000_0001);
        wr(clk_ctrl_pkg::ADDR_PLL_TEST, 32'h0000_0001, rsp);
        chk(pll_half_o, 32'h0000_0001);
        opt_pll_en_i <= 1'b0;
        settle();
        chk(timer_mul_en_o, 32'h0000_0000);
        opt_src_i <= clk_ctrl_pkg::SRC_EXT;
        settle();
        chk(src_sel_o, clk_ctrl_pkg::SRC_EXT);
        opt_src_i <= clk_ctrl_pkg::SRC_XTAL;
        settle();
        chk(src_sel_o, clk_ctrl_pkg::SRC_XTAL);
        prog_entry_i <= 1'b1;
        settle();
        chk(src_sel_o, clk_ctrl_pkg::SRC_RC);
        prog_entry_i <= 1'b0;
        chk(core_en_o, 32'h0000_0001);
        wr(clk_ctrl_pkg::ADDR_CLK_CTRL, 32'h0000_0001, rsp);
        g = 1;
        for (int k = 0; k < 40 && g == 1; k++)
            gap(g);
        chk(g, 32'h0000_0020);
        gap(g);
        chk(g, 32'h0000_0020);
        wr(clk_ctrl_pkg::ADDR_CLK_CTRL, 32'h0000_0000, rsp);
        repeat (80) @(posedge clk_i);
        chk(core_en_o, 32'h0000_0001);
        do_reset();
        rd_chk(clk_ctrl_pkg::ADDR_TRIM_HIGH, 32'hffff_ffff, 32'h0000_00ff);
        chk(rc_trim_code_o, 32'h0000_03ff);
        rd_chk(clk_ctrl_pkg::ADDR_CLK_CTRL, 32'hffff_ffff, 32'h0000_0000);
        test_done();
    end
endmodule // clk_ctrl_tb
